// ### design/phm_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants of the health monitor and discharge counter block
////////////////////////////////////////////////////////////////////////////////
package phm_pkg;

    // Register addresses
    localparam logic [15:0] ADDR_INT_ONE = 16'h0012;
    localparam logic [15:0] ADDR_INT_TWO = 16'h0013;
    localparam logic [15:0] ADDR_DISCHARGE = 16'h0448;
    localparam logic [15:0] ADDR_CYCLE_CFG = 16'h0480;
    localparam logic [15:0] ADDR_PERIODIC_CTL = 16'h0481;
    localparam logic [15:0] ADDR_THRESH_CFG = 16'h0482;
    localparam logic [15:0] ADDR_TEMP_READ = 16'h0483;
    localparam logic [15:0] ADDR_VOLT_READ = 16'h0484;

    // Values after reset
    localparam logic [15:0] RST_CYCLE_CFG = 16'h0002;
    localparam logic [15:0] RST_PERIODIC_CTL = 16'h0003;
    localparam logic [15:0] RST_THRESH_CFG = 16'h0000;
    localparam logic [7:0] RST_INT_EN = 8'h00;

    // Field positions
    localparam int CYCLE_LSB = 0;
    localparam int PERIODIC_VOLT_BIT = 0;
    localparam int PERIODIC_TEMP_BIT = 1;
    localparam int TEMP_TRIP_LSB = 0;
    localparam int VOLT_TRIP_LSB = 12;
    localparam int EN_DISCHARGE_BIT = 3;
    localparam int EN_OVERTEMP_BIT = 3;
    localparam int EN_OVERVOLT_BIT = 6;
    localparam int EN_UNDERVOLT_BIT = 7;
    localparam int ST_DISCHARGE_BIT = 11;
    localparam int ST_OVERTEMP_BIT = 11;
    localparam int ST_OVERVOLT_BIT = 14;
    localparam int ST_UNDERVOLT_BIT = 15;
    localparam int IO_RANGE_LSB = 0;
    localparam int CORE_RANGE_LSB = 8;
    localparam int MAC_COUNT_LSB = 8;
    localparam int LINE_COUNT_LSB = 0;

    // Field widths
    localparam int RANGE_W = 3;
    localparam int COUNT_W = 6;

    // Timing: one cycle-time step is 16 ms
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_TIME_MS = 16;
    localparam int STEP_CYCLES = STEP_TIME_MS * 1000000 / CLK_PERIOD_NS;

endpackage

// ### design/phm_monitor.sv
// Behaviour
// - Voltage monitor samples periodically, default 32 ms
// - Cycle time from 4-bit field, bits 3:0
// - Periodic control register stops periodic monitoring
// - Temperature monitor shares cycle and default
// - Voltage readout updated each voltage cycle
// - Temperature range code updated each cycle
// - Enable bits for undervoltage and overvoltage interrupts
// - Threshold register sets voltage trip points
// - Low four bits set overtemperature threshold
// - Enabled overtemperature drives interrupt pin
// - Two discharge counters, MAC and line side
// - Discharge sensors always run, unconfigured
// - Counts cleared only by power-up reset
// - Counts at bits 13:8 and 5:0
// - Discharge interrupt enable bit 3
`timescale 1ns/1ps
module phm_monitor
#(
    parameter int STEP_CYCLES = phm_pkg::STEP_CYCLES
)
(
    // Clock and power-up reset
    input wire logic CLK,
    input wire logic NRST,
    // Register port
    input wire logic [15:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    // Analog sensor side
    input wire logic [2:0] TEMP_RANGE,
    input wire logic [2:0] IO_RANGE,
    input wire logic [2:0] CORE_RANGE,
    input wire logic UNDERVOLT,
    input wire logic OVERVOLT,
    input wire logic OVERTEMP,
    output logic [3:0] VOLT_TRIP,
    output logic [3:0] TEMP_TRIP,
    output logic VOLT_SAMPLE,
    output logic TEMP_SAMPLE,
    // Discharge event pulses
    input wire logic ESD_MAC_EVENT,
    input wire logic ESD_LINE_EVENT,
    // Interrupt pin
    output logic INT_N
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] cycle_cfg;
    logic [15:0] periodic_ctl;
    logic [15:0] thresh_cfg;
    logic [7:0] int_en_one;
    logic [7:0] int_en_two;
    logic [2:0] temp_read;
    logic [2:0] io_read;
    logic [2:0] core_read;
    logic st_discharge;
    logic st_overtemp;
    logic st_overvolt;
    logic st_undervolt;
    logic [5:0] esd_count [2];
    logic [1:0] esd_event;
    logic [3:0] cycle_code;
    logic volt_on;
    logic temp_on;
    logic [31:0] step_cnt;
    logic [3:0] step_num;
    logic step_done;
    logic period_end;
    logic volt_tick;
    logic temp_tick;
    logic wr_cycle;
    logic rd_int_one;
    logic rd_int_two;

    assign cycle_code = cycle_cfg[phm_pkg::CYCLE_LSB +: 4];
    assign volt_on = periodic_ctl[phm_pkg::PERIODIC_VOLT_BIT];
    assign temp_on = periodic_ctl[phm_pkg::PERIODIC_TEMP_BIT];
    assign wr_cycle = REG_WR && (REG_ADDR == phm_pkg::ADDR_CYCLE_CFG);
    assign rd_int_one = REG_RD && (REG_ADDR == phm_pkg::ADDR_INT_ONE);
    assign rd_int_two = REG_RD && (REG_ADDR == phm_pkg::ADDR_INT_TWO);
    assign esd_event = {ESD_MAC_EVENT, ESD_LINE_EVENT};

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cycle_cfg <= phm_pkg::RST_CYCLE_CFG;
            periodic_ctl <= phm_pkg::RST_PERIODIC_CTL;
            thresh_cfg <= phm_pkg::RST_THRESH_CFG;
            int_en_one <= phm_pkg::RST_INT_EN;
            int_en_two <= phm_pkg::RST_INT_EN;
        end
        else if (REG_WR)
        begin
            case (REG_ADDR)
                phm_pkg::ADDR_CYCLE_CFG: cycle_cfg <= REG_WDATA;
                phm_pkg::ADDR_PERIODIC_CTL: periodic_ctl <= REG_WDATA;
                phm_pkg::ADDR_THRESH_CFG: thresh_cfg <= REG_WDATA;
                phm_pkg::ADDR_INT_ONE: int_en_one <= REG_WDATA[7:0];
                phm_pkg::ADDR_INT_TWO: int_en_two <= REG_WDATA[7:0];
                default:
                begin
                end
            endcase
        end
    end

    // Trip levels reach the analog comparators through one register stage
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            VOLT_TRIP <= 4'h0;
            TEMP_TRIP <= 4'h0;
        end
        else
        begin
            VOLT_TRIP <= thresh_cfg[phm_pkg::VOLT_TRIP_LSB +: 4];
            TEMP_TRIP <= thresh_cfg[phm_pkg::TEMP_TRIP_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Monitor cycle timer
    ////////////////////////////////////////////////////////////////////////////
    assign step_done = (step_cnt == 32'(STEP_CYCLES - 1));
    assign period_end = step_done && (step_num == cycle_code);

    // Code zero is illegal; the timer then idles instead of spinning
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            step_cnt <= 32'h0000_0000;
            step_num <= 4'h1;
        end
        else if (wr_cycle || !(volt_on || temp_on) || cycle_code == 4'h0)
        begin
            step_cnt <= 32'h0000_0000;
            step_num <= 4'h1;
        end
        else if (step_done)
        begin
            step_cnt <= 32'h0000_0000;
            step_num <= period_end ? 4'h1 : step_num + 4'h1;
        end
        else
        begin
            step_cnt <= step_cnt + 32'h0000_0001;
        end
    end

    assign volt_tick = period_end && volt_on && !wr_cycle;
    assign temp_tick = period_end && temp_on && !wr_cycle;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            VOLT_SAMPLE <= 1'b0;
            TEMP_SAMPLE <= 1'b0;
        end
        else
        begin
            VOLT_SAMPLE <= volt_tick;
            TEMP_SAMPLE <= temp_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readouts
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            io_read <= 3'h0;
            core_read <= 3'h0;
        end
        else if (volt_tick)
        begin
            io_read <= IO_RANGE;
            core_read <= CORE_RANGE;
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            temp_read <= 3'h0;
        end
        else if (temp_tick)
        begin
            temp_read <= TEMP_RANGE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Discharge counters, saturating, cleared by power-up only
    ////////////////////////////////////////////////////////////////////////////
    generate
        for (genvar g = 0; g < 2; g++)
        begin : gen_esd
            always_ff @(posedge CLK or negedge NRST)
            begin
                if (!NRST)
                begin
                    esd_count[g] <= 6'h00;
                end
                else if (esd_event[g] && esd_count[g] != 6'h3F)
                begin
                    esd_count[g] <= esd_count[g] + 6'h01;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status: read clears, a new event in the same cycle wins
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_discharge <= 1'b0;
        end
        else if (|esd_event)
        begin
            st_discharge <= 1'b1;
        end
        else if (rd_int_one)
        begin
            st_discharge <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_overtemp <= 1'b0;
        end
        else if (temp_tick && OVERTEMP)
        begin
            st_overtemp <= 1'b1;
        end
        else if (rd_int_two)
        begin
            st_overtemp <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_overvolt <= 1'b0;
            st_undervolt <= 1'b0;
        end
        else
        begin
            if (volt_tick && OVERVOLT)
            begin
                st_overvolt <= 1'b1;
            end
            else if (rd_int_two)
            begin
                st_overvolt <= 1'b0;
            end
            if (volt_tick && UNDERVOLT)
            begin
                st_undervolt <= 1'b1;
            end
            else if (rd_int_two)
            begin
                st_undervolt <= 1'b0;
            end
        end
    end

    // Pin low while any enabled status is pending
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            INT_N <= 1'b1;
        end
        else
        begin
            INT_N <= !((st_discharge && int_en_one[phm_pkg::EN_DISCHARGE_BIT])
                || (st_overtemp && int_en_two[phm_pkg::EN_OVERTEMP_BIT])
                || (st_overvolt && int_en_two[phm_pkg::EN_OVERVOLT_BIT])
                || (st_undervolt && int_en_two[phm_pkg::EN_UNDERVOLT_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            REG_RDATA <= 16'h0000;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RVALID <= REG_RD;
            REG_RDATA <= 16'h0000;
            if (REG_RD)
            begin
                case (REG_ADDR)
                    phm_pkg::ADDR_INT_ONE:
                    begin
                        REG_RDATA[7:0] <= int_en_one;
                        REG_RDATA[phm_pkg::ST_DISCHARGE_BIT] <= st_discharge;
                    end
                    phm_pkg::ADDR_INT_TWO:
                    begin
                        REG_RDATA[7:0] <= int_en_two;
                        REG_RDATA[phm_pkg::ST_OVERTEMP_BIT] <= st_overtemp;
                        REG_RDATA[phm_pkg::ST_OVERVOLT_BIT] <= st_overvolt;
                        REG_RDATA[phm_pkg::ST_UNDERVOLT_BIT] <= st_undervolt;
                    end
                    phm_pkg::ADDR_DISCHARGE:
                    begin
                        REG_RDATA[phm_pkg::MAC_COUNT_LSB +: 6] <= esd_count[1];
                        REG_RDATA[phm_pkg::LINE_COUNT_LSB +: 6] <= esd_count[0];
                    end
                    phm_pkg::ADDR_CYCLE_CFG: REG_RDATA <= cycle_cfg;
                    phm_pkg::ADDR_PERIODIC_CTL: REG_RDATA <= periodic_ctl;
                    phm_pkg::ADDR_THRESH_CFG: REG_RDATA <= thresh_cfg;
                    phm_pkg::ADDR_TEMP_READ:
                    begin
                        REG_RDATA[2:0] <= temp_read;
                    end
                    phm_pkg::ADDR_VOLT_READ:
                    begin
                        REG_RDATA[phm_pkg::IO_RANGE_LSB +: 3] <= io_read;
                        REG_RDATA[phm_pkg::CORE_RANGE_LSB +: 3] <= core_read;
                    end
                    default: REG_RDATA <= 16'h0000;
                endcase
            end
        end
    end

endmodule

// ### testbench/phm_monitor_assertions.sv
`timescale 1ns/1ps
module phm_monitor_assertions
#(
    parameter int STEP_CYCLES = 10
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Register port
    input wire logic [15:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_RVALID,
    // Sensor side and pin
    input wire logic OVERTEMP,
    input wire logic [3:0] VOLT_TRIP,
    input wire logic [3:0] TEMP_TRIP,
    input wire logic VOLT_SAMPLE,
    input wire logic TEMP_SAMPLE,
    input wire logic ESD_MAC_EVENT,
    input wire logic INT_N
);
    logic [7:0] en_one;
    logic [7:0] en_two;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the interrupt enables
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            en_one <= 8'h00;
        else if (REG_WR && REG_ADDR == 16'h0012)
            en_one <= REG_WDATA[7:0];
    end
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            en_two <= 8'h00;
        else if (REG_WR && REG_ADDR == 16'h0013)
            en_two <= REG_WDATA[7:0];
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_trip_write;
        REG_WR && REG_ADDR == 16'h0482;
    endsequence
    sequence s_hot_sample;
        TEMP_SAMPLE && $past(OVERTEMP) && en_two[3];
    endsequence
    sequence s_event_enabled;
        ESD_MAC_EVENT ##1 en_one[3];
    endsequence
    a_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered next cycle");
    a_valid_only_read: assert property (!REG_RD |=> !REG_RVALID)
        else $error("read valid without a read");
    a_rdata_idle: assert property (!REG_RVALID |-> REG_RDATA == 16'h0000)
        else $error("read data not zero when idle");
    a_trip_forward: assert property (s_trip_write |=> ##1
        (TEMP_TRIP == $past(REG_WDATA[3:0], 2) && VOLT_TRIP == $past(REG_WDATA[15:12], 2)))
        else $error("trip codes do not follow threshold write");
    a_hot_interrupt: assert property (s_hot_sample |=> !INT_N)
        else $error("overtemperature did not pull interrupt low");
    a_event_interrupt: assert property (s_event_enabled |=> !INT_N)
        else $error("discharge event did not pull interrupt low");
    a_count_fields: assert property (REG_RD && REG_ADDR == 16'h0448 |=>
        REG_RDATA[15:14] == 2'h0 && REG_RDATA[7:6] == 2'h0)
        else $error("discharge counts outside their fields");
    a_volt_spacing: assert property (VOLT_SAMPLE |=> (!VOLT_SAMPLE) [*8])
        else $error("voltage samples too close");
    a_temp_pulse: assert property ($rose(TEMP_SAMPLE) |=> $fell(TEMP_SAMPLE))
        else $error("temperature sample pulse too long");
endmodule
bind phm_monitor phm_monitor_assertions #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.CLK(CLK),
    .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .OVERTEMP(OVERTEMP),
    .VOLT_TRIP(VOLT_TRIP), .TEMP_TRIP(TEMP_TRIP), .VOLT_SAMPLE(VOLT_SAMPLE),
    .TEMP_SAMPLE(TEMP_SAMPLE), .ESD_MAC_EVENT(ESD_MAC_EVENT), .INT_N(INT_N));

// ### testbench/phm_smi_host.sv
`timescale 1ns/1ps
module phm_smi_host
(
    // Clock
    input wire logic clk,
    // Requests
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    // Answers
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Idle address and data show the inverse of the last word, not a held value
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        if (addr == 16'h0480 && data[3:0] == 4'h0)
            return;
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask
    task automatic rd(input logic [15:0] addr, output logic [15:0] data);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask
endmodule

// ### testbench/phm_monitor_bench.sv
`timescale 1ns/1ps
module phm_monitor_bench;
    localparam int STEP = 10;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] temp_range = 3'h0;
    logic [2:0] io_range = 3'h0;
    logic [2:0] core_range = 3'h0;
    logic [2:0] flt = 3'h0;
    logic esd_mac = 1'b0;
    logic esd_line = 1'b0;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, reg_rvalid, volt_sample, temp_sample, int_n;
    logic [3:0] volt_trip, temp_trip;
    int err_total = 0;
    int cmp_count = 0;
    int n;
    always #5 clk = ~clk;
    phm_smi_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    phm_monitor #(.STEP_CYCLES(STEP)) u_dut (.CLK(clk), .NRST(nrst), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .TEMP_RANGE(temp_range), .IO_RANGE(io_range),
        .CORE_RANGE(core_range), .UNDERVOLT(flt[2]), .OVERVOLT(flt[1]), .OVERTEMP(flt[0]),
        .VOLT_TRIP(volt_trip), .TEMP_TRIP(temp_trip), .VOLT_SAMPLE(volt_sample),
        .TEMP_SAMPLE(temp_sample), .ESD_MAC_EVENT(esd_mac), .ESD_LINE_EVENT(esd_line),
        .INT_N(int_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_pulse(input logic temp, output int cnt);
        for (cnt = 1; cnt < 4000; cnt++)
        begin
            @(posedge clk);
            #1;
            if ((temp ? temp_sample : volt_sample) === 1'b1)
                return;
        end
        err_total++;
        $display("BAD %0t no sample pulse", $time);
        end_sim();
    endtask
    task automatic pulse(input logic mac, input int len);
        @(posedge clk);
        esd_mac <= mac;
        esd_line <= !mac;
        repeat (len) @(posedge clk);
        esd_mac <= 1'b0;
        esd_line <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        logic [15:0] adr [9] = '{16'h0483, 16'h0484, 16'h0480, 16'h0481, 16'h0482,
            16'h0448, 16'h0012, 16'h0013, 16'h0100};
        logic [15:0] exp [9] = '{16'h0000, 16'h0000, 16'h0002, 16'h0003, 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 16'h0000};
        chk(16'(int_n), 16'h0001);
        for (int i = 0; i < 9; i++)
        begin
            u_host.rd(adr[i], d);
            chk(d, exp[i]);
        end
    endtask
    task automatic t_period();
        logic [3:0] codes [4] = '{4'h2, 4'h1, 4'h9, 4'hF};
        for (int i = 0; i < 4; i++)
        begin
            if (i > 0)
                u_host.wr(16'h0480, {12'h000, codes[i]});
            @(posedge clk);
            io_range <= codes[i][2:0];
            core_range <= ~codes[i][2:0];
            temp_range <= codes[i][2:0] + 3'h1;
            wait_pulse(1'b0, n);
            wait_pulse(1'b0, n);
            chk(16'(n), 16'(codes[i]) * 16'(STEP));
            u_host.rd(16'h0484, d);
            chk(d, {5'h00, ~codes[i][2:0], 5'h00, codes[i][2:0]});
            u_host.rd(16'h0483, d);
            chk(d, {13'h0000, codes[i][2:0] + 3'h1});
        end
    endtask
    task automatic t_periodic_ctl();
        int nv;
        int nt;
        u_host.wr(16'h0480, 16'h0001);
        for (int c = 0; c < 4; c++)
        begin
            u_host.wr(16'h0481, 16'(c));
            nv = 0;
            nt = 0;
            repeat (4 * STEP)
            begin
                @(posedge clk);
                #1;
                nv += int'(volt_sample === 1'b1);
                nt += int'(temp_sample === 1'b1);
            end
            chk(16'(nv > 0), 16'(c % 2));
            chk(16'(nt > 0), 16'(c / 2));
        end
    endtask
    task automatic t_thresholds();
        u_host.wr(16'h0482, 16'h1004);
        @(posedge clk);
        #1;
        chk({volt_trip, 8'h00, temp_trip}, 16'h1004);
        u_host.rd(16'h0482, d);
        chk(d, 16'h1004);
    endtask
    task automatic t_interrupts();
        logic [7:0] en [4] = '{8'h80, 8'h40, 8'h08, 8'h00};
        logic [2:0] src [4] = '{3'h4, 3'h2, 3'h1, 3'h1};
        logic [15:0] st [4] = '{16'h8000, 16'h4000, 16'h0800, 16'h0800};
        for (int i = 0; i < 4; i++)
        begin
            u_host.wr(16'h0013, {8'h00, en[i]});
            @(posedge clk);
            flt <= src[i];
            wait_pulse(src[i][0], n);
            wait_pulse(src[i][0], n);
            @(posedge clk);
            flt <= 3'h0;
            @(posedge clk);
            #1;
            chk(16'(int_n), 16'(en[i] == 8'h00));
            u_host.rd(16'h0013, d);
            chk(d, st[i] | {8'h00, en[i]});
            @(posedge clk);
            #1;
            chk(16'(int_n), 16'h0001);
        end
    endtask
    task automatic t_discharge();
        u_host.wr(16'h0012, 16'h0008);
        pulse(1'b1, 3);
        pulse(1'b0, 2);
        @(posedge clk);
        #1;
        chk(16'(int_n), 16'h0000);
        u_host.rd(16'h0448, d);
        chk(d, 16'h0302);
        u_host.rd(16'h0012, d);
        chk(d, 16'h0808);
        u_host.wr(16'h0448, 16'hFFFF);
        u_host.rd(16'h0448, d);
        chk(d, 16'h0302);
        pulse(1'b0, 70);
        u_host.rd(16'h0448, d);
        chk(d, 16'h033F);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        u_host.rd(16'h0448, d);
        chk(d, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_reset_values();
        t_period();
        t_periodic_ctl();
        t_thresholds();
        t_interrupts();
        t_discharge();
        end_sim();
    end
endmodule
